// *** alu_ops_pkg.sv ***
// constants and types for the byte and bit instruction datapath
package alu_ops_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W  = 3;
   localparam int NIB_W  = 4;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic              DEST_ACC  = 1'h0;
   localparam logic              DEST_REG  = 1'h1;
   localparam logic [ADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01;

   typedef enum logic [7:0] {
      OP_NONE              = 8'h00,
      OP_ADD_LITERAL_ACC   = 8'h01,
      OP_ADD_ACC_REG       = 8'h02,
      OP_AND_LITERAL_ACC   = 8'h03,
      OP_AND_ACC_REG       = 8'h04,
      OP_CLEAR_REG_BIT     = 8'h05,
      OP_SET_REG_BIT       = 8'h06,
      OP_TEST_SKIP_ONE     = 8'h07,
      OP_TEST_SKIP_ZERO    = 8'h08
   } op_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'h1,
      ST_SKIP = 2'h2
   } state_t;
endpackage

// *** byte_bit_alu_ops.sv ***
// execution datapath for add, and, bit set/clear and bit-test-skip
`timescale 1ns/1ps
module byte_bit_alu_ops #(
   parameter int DATA_W = alu_ops_pkg::DATA_W,
   parameter int ADDR_W = alu_ops_pkg::ADDR_W
) (
   input  wire logic              clk_in,           // core clock, 200 MHz
   input  wire logic              rst_n_in,         // async reset, active low
   input  wire logic              cycle_en_in,      // one-cycle instruction cycle enable
   input  wire logic              issue_in,         // instruction valid this cycle
   input  wire alu_ops_pkg::op_t  op_in,            // decoded operation
   input  wire logic [DATA_W-1:0] literal_in,       // 8-bit literal
   input  wire logic [ADDR_W-1:0] reg_addr_in,      // file register address
   input  wire logic              dest_in,          // 0 accumulator, 1 register
   input  wire logic [2:0]        bit_sel_in,       // bit position
   input  wire logic [DATA_W-1:0] reg_rdata_in,     // file register contents
   input  wire logic              reg_is_port_in,   // addressed register is a port
   input  wire logic [DATA_W-1:0] pin_value_in,     // sensed pin levels of that port
   input  wire logic              psc_on_timer_in,  // prescaler assigned to timer zero
   output logic [DATA_W-1:0]      acc_out,          // accumulator
   output logic                   carry_out,        // carry flag
   output logic                   nibble_overflow_flag_out, // digit carry flag
   output logic                   zero_out,         // zero flag
   output logic                   reg_we_out,       // file register write strobe
   output logic [ADDR_W-1:0]      reg_waddr_out,    // file register write address
   output logic [DATA_W-1:0]      reg_wdata_out,    // file register write data
   output logic                   prescaler_clr_out,// clear timer zero prescaler
   output logic                   discard_out,      // current slot is a forced no-op
   output logic                   busy_out          // instruction accepted this cycle
);
   alu_ops_pkg::state_t state;
   alu_ops_pkg::state_t next_state;

   wire take = cycle_en_in && issue_in && (state == alu_ops_pkg::ST_RUN);
   logic [DATA_W-1:0] pin_meta;
   logic [DATA_W-1:0] pin_sync;

   // pins are asynchronous: two flops before anything reads them,
   // so a port operand lags the pads by two clocks
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta <= alu_ops_pkg::ZERO_BYTE;
         pin_sync <= alu_ops_pkg::ZERO_BYTE;
      end else begin
         pin_meta <= pin_value_in;
         pin_sync <= pin_meta;
      end
   end

   // self-modify of a port reads the pins, not the latch
   wire [DATA_W-1:0] src = reg_is_port_in ? pin_sync : reg_rdata_in;
   wire is_add_l = op_in == alu_ops_pkg::OP_ADD_LITERAL_ACC;
   wire is_add_r = op_in == alu_ops_pkg::OP_ADD_ACC_REG;
   wire is_and_l = op_in == alu_ops_pkg::OP_AND_LITERAL_ACC;
   wire is_and_r = op_in == alu_ops_pkg::OP_AND_ACC_REG;
   wire is_clr   = op_in == alu_ops_pkg::OP_CLEAR_REG_BIT;
   wire is_set   = op_in == alu_ops_pkg::OP_SET_REG_BIT;
   wire is_t1    = op_in == alu_ops_pkg::OP_TEST_SKIP_ONE;
   wire is_t0    = op_in == alu_ops_pkg::OP_TEST_SKIP_ZERO;
   wire [DATA_W-1:0] add_b = is_add_l ? literal_in : src;
   wire [DATA_W:0] sum = {1'b0, acc_out} + {1'b0, add_b};
   wire [alu_ops_pkg::NIB_W:0] nib_sum = {1'b0, acc_out[alu_ops_pkg::NIB_W-1:0]}
                                        + {1'b0, add_b[alu_ops_pkg::NIB_W-1:0]};
   wire [DATA_W-1:0] and_res = acc_out & (is_and_l ? literal_in : src);
   wire [DATA_W-1:0] mask = DATA_W'(1) << bit_sel_in;
   wire [DATA_W-1:0] bit_res = is_set ? (src | mask) : (src & ~mask);
   wire tested = src[bit_sel_in];
   wire do_skip = (is_t1 && tested) || (is_t0 && !tested);
   wire is_add = is_add_l || is_add_r;
   wire is_and = is_and_l || is_and_r;
   wire [DATA_W-1:0] result = is_add ? sum[DATA_W-1:0] : (is_and ? and_res : bit_res);
   wire to_acc = is_add_l || is_and_l || ((is_add_r || is_and_r) && dest_in == alu_ops_pkg::DEST_ACC);
   wire to_reg = ((is_add_r || is_and_r) && dest_in == alu_ops_pkg::DEST_REG) || is_clr || is_set;
   wire res_zero = result == alu_ops_pkg::ZERO_BYTE;

   always_comb begin
      next_state = state;
      unique case (state)
         alu_ops_pkg::ST_RUN:  if (take && do_skip) next_state = alu_ops_pkg::ST_SKIP;
         alu_ops_pkg::ST_SKIP: if (cycle_en_in) next_state = alu_ops_pkg::ST_RUN;
         default:              next_state = alu_ops_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) state <= alu_ops_pkg::ST_RUN;
      else state <= next_state;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_out <= alu_ops_pkg::ACC_RESET;
         carry_out <= 1'b0;
         nibble_overflow_flag_out <= 1'b0;
         zero_out <= 1'b0;
      end else if (take) begin
         if (to_acc) acc_out <= result;
         if (is_add) begin
            carry_out <= sum[DATA_W];
            nibble_overflow_flag_out <= nib_sum[alu_ops_pkg::NIB_W];
         end
         if (is_add || is_and) zero_out <= res_zero;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_we_out <= 1'b0;
         reg_waddr_out <= '0;
         reg_wdata_out <= alu_ops_pkg::ZERO_BYTE;
         prescaler_clr_out <= 1'b0;
      end else begin
         reg_we_out <= take && to_reg;
         // timer zero written by a byte or bit op drops the prescaler when it is assigned to timer zero
         prescaler_clr_out <= take && to_reg && psc_on_timer_in
                              && reg_addr_in == alu_ops_pkg::TIMER_ZERO_ADDR;
         if (take && to_reg) begin
            reg_waddr_out <= reg_addr_in;
            reg_wdata_out <= result;
         end
      end
   end

   assign discard_out = state == alu_ops_pkg::ST_SKIP;
   assign busy_out = take;

   // a taken skip: the test fires, then the next slot is dropped
   sequence skip_taken_s;
      take && do_skip;
   endsequence

   sequence slot_dropped_s;
      discard_out && !busy_out && !reg_we_out;
   endsequence

   sequence slot_released_s;
      discard_out && cycle_en_in;
   endsequence

   add_carry_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_add |=> carry_out == $past(sum[DATA_W]))
      else $error("carry does not match addition");
   add_acc_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_add_l |=> acc_out == $past(acc_out + literal_in))
      else $error("literal add result wrong");
   dest_reg_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && (is_add_r || is_and_r) && dest_in |=> reg_we_out && $stable(acc_out))
      else $error("register destination not honoured");
   and_flags_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_and |=> $stable(carry_out) && $stable(nibble_overflow_flag_out))
      else $error("and changed carry flags");
   and_reg_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_and_r && !dest_in |=> zero_out == (acc_out == alu_ops_pkg::ZERO_BYTE))
      else $error("and zero flag wrong");
   bit_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_clr |=> reg_we_out && !reg_wdata_out[$past(bit_sel_in)] && $stable(zero_out))
      else $error("bit clear wrong");
   bit_set_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_set |=> reg_we_out && reg_wdata_out[$past(bit_sel_in)] && $stable(carry_out))
      else $error("bit set wrong");
   skip_one_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_t1 && tested |=> discard_out && !reg_we_out)
      else $error("skip on one missing");
   skip_zero_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_t0 && !tested |=> slot_dropped_s)
      else $error("skip on zero missing");
   no_skip_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && !do_skip |=> !discard_out)
      else $error("unexpected skip");
   psc_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      prescaler_clr_out |-> reg_we_out && reg_waddr_out == alu_ops_pkg::TIMER_ZERO_ADDR)
      else $error("prescaler clear without timer write");

   skip_span_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      skip_taken_s ##1 slot_released_s |=> !discard_out)
      else $error("skip lasted past one slot");

   skip_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      discard_out && !cycle_en_in |=> discard_out)
      else $error("skip slot ended early");

   skip_end_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      slot_released_s |=> !discard_out)
      else $error("skip slot not released");

   drop_issue_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      discard_out |-> !busy_out)
      else $error("instruction taken in dropped slot");

   add_reg_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_add_r && dest_in == alu_ops_pkg::DEST_REG |=> reg_wdata_out == $past(acc_out + src))
      else $error("register add write data wrong");

   add_dest_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_add_r && dest_in == alu_ops_pkg::DEST_ACC |=> acc_out == $past(acc_out + src) && !reg_we_out)
      else $error("register add to accumulator wrong");

   and_lit_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_and_l |=> acc_out == ($past(acc_out) & $past(literal_in)))
      else $error("literal and result wrong");

   and_dest_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_and_r && dest_in == alu_ops_pkg::DEST_REG
      |=> reg_wdata_out == ($past(acc_out) & $past(src)) && $stable(acc_out))
      else $error("register and write data wrong");

   zero_flag_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_add_l |=> zero_out == (acc_out == alu_ops_pkg::ZERO_BYTE))
      else $error("add zero flag wrong");

   bit_clear_keep_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_clr && !reg_is_port_in
      |=> reg_wdata_out == ($past(reg_rdata_in) & ~(DATA_W'(1) << $past(bit_sel_in))))
      else $error("bit clear touched other bits");

   bit_set_keep_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_set && !reg_is_port_in
      |=> reg_wdata_out == ($past(reg_rdata_in) | (DATA_W'(1) << $past(bit_sel_in))))
      else $error("bit set touched other bits");

   port_src_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && is_set && reg_is_port_in
      |=> reg_wdata_out == ($past(pin_sync) | (DATA_W'(1) << $past(bit_sel_in))))
      else $error("port write back not from pins");

   bit_flags_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && (is_clr || is_set) |=> $stable(acc_out) && $stable(zero_out) && $stable(nibble_overflow_flag_out))
      else $error("bit operation changed flags");

   psc_set_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && to_reg && psc_on_timer_in && reg_addr_in == alu_ops_pkg::TIMER_ZERO_ADDR |=> prescaler_clr_out)
      else $error("timer write kept prescaler");

   test_quiet_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      take && (is_t1 || is_t0) |=> $stable(acc_out) && $stable(zero_out) && !reg_we_out)
      else $error("bit test changed state");
endmodule

// *** test_byte_bit_alu_ops.sv ***
// self-checking bench for the byte and bit instruction datapath
`timescale 1ns/1ps
module test_byte_bit_alu_ops;
   logic             clk_in = 1'b0;
   logic             rst_n_in = 1'b0;
   logic             cycle_en_in = 1'b0, issue_in = 1'b0, dest_in = 1'b0;
   logic             reg_is_port_in = 1'b0, psc_on_timer_in = 1'b0;
   alu_ops_pkg::op_t op_in = alu_ops_pkg::OP_NONE;
   logic [7:0]       literal_in = 8'h00, reg_rdata_in = 8'h00, pin_value_in = 8'h00;
   logic [6:0]       reg_addr_in = 7'h00;
   logic [2:0]       bit_sel_in = 3'h0;
   logic [7:0]       acc_out, reg_wdata_out;
   logic [6:0]       reg_waddr_out;
   logic             carry_out, nibble_overflow_flag_out, zero_out, reg_we_out;
   logic             prescaler_clr_out, discard_out, busy_out;
   logic [7:0]       acc = 8'h00, wd = 8'h00, pin_d1 = 8'h00, pin_d2 = 8'h00, src, opnd, res, o;
   logic [6:0]       wa = 7'h00;
   logic             c = 1'b0, nc = 1'b0, z = 1'b0, disc = 1'b0, tk, we, pc;
   logic [8:0]       sum;
   logic [4:0]       n4;
   logic [28:0]      note_q[$];
   logic [28:0]      seen;
   int               fail_count = 0, checked = 0;

   byte_bit_alu_ops dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .cycle_en_in(cycle_en_in), .issue_in(issue_in),
      .op_in(op_in), .literal_in(literal_in), .reg_addr_in(reg_addr_in), .dest_in(dest_in), .bit_sel_in(bit_sel_in),
      .reg_rdata_in(reg_rdata_in), .reg_is_port_in(reg_is_port_in), .pin_value_in(pin_value_in),
      .psc_on_timer_in(psc_on_timer_in), .acc_out(acc_out), .carry_out(carry_out),
      .nibble_overflow_flag_out(nibble_overflow_flag_out), .zero_out(zero_out), .reg_we_out(reg_we_out),
      .reg_waddr_out(reg_waddr_out), .reg_wdata_out(reg_wdata_out), .prescaler_clr_out(prescaler_clr_out),
      .discard_out(discard_out), .busy_out(busy_out));

   always #2.5 clk_in = ~clk_in;

   task automatic final_report;
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // one random instruction slot; model updated before the launching edge
   task automatic step;
      @(negedge clk_in);
      o = 8'(($urandom % 8) + 1);
      op_in = alu_ops_pkg::op_t'(o);
      cycle_en_in = ($urandom % 6) != 0;
      issue_in = ($urandom % 8) != 0;
      literal_in = 8'($urandom);
      reg_rdata_in = 8'($urandom);
      pin_value_in = 8'($urandom);
      reg_addr_in = ($urandom % 4 == 0) ? alu_ops_pkg::TIMER_ZERO_ADDR : 7'($urandom);
      dest_in = 1'($urandom);
      bit_sel_in = 3'($urandom);
      psc_on_timer_in = 1'($urandom);
      // bit tests keep pins out: only ops 01 to 06 (add, and, bit set/clear) may address a port here
      reg_is_port_in = (o < 8'h07) && 1'($urandom);
      // pins reach the datapath through two flops
      src = reg_is_port_in ? pin_d2 : reg_rdata_in;
      pin_d2 = pin_d1;
      pin_d1 = pin_value_in;
      opnd = (o == 8'h01 || o == 8'h03) ? literal_in : src;
      tk = cycle_en_in && issue_in && !disc;
      #1;
      checked++;
      if (busy_out !== tk) begin
         fail_count++;
         $display("unexpected busy_out exp %b got %b", tk, busy_out);
      end
      we = 1'b0;
      if (cycle_en_in) disc = 1'b0;
      if (tk && o < 8'h05) begin
         sum = {1'b0, acc} + {1'b0, opnd};
         n4 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
         res = (o < 8'h03) ? sum[7:0] : (acc & opnd);
         z = (res == 8'h00);
         if (o < 8'h03) {c, nc} = {sum[8], n4[4]};
         if (o == 8'h01 || o == 8'h03 || dest_in == 1'b0) acc = res;
         else {we, wa, wd} = {1'b1, reg_addr_in, res};
      end
      if (tk && o == 8'h05) {we, wa, wd} = {1'b1, reg_addr_in, src & ~(8'h01 << bit_sel_in)};
      if (tk && o == 8'h06) {we, wa, wd} = {1'b1, reg_addr_in, src | (8'h01 << bit_sel_in)};
      if (tk && o == 8'h07) disc = src[bit_sel_in];
      if (tk && o == 8'h08) disc = !src[bit_sel_in];
      pc = we && wa == alu_ops_pkg::TIMER_ZERO_ADDR && psc_on_timer_in;
      note_q.push_back({acc, c, nc, z, we, wa, wd, pc, disc});
   endtask

   always @(posedge clk_in) begin
      #1;
      if (note_q.size() > 0) begin
         seen = {acc_out, carry_out, nibble_overflow_flag_out, zero_out, reg_we_out, reg_waddr_out,
            reg_wdata_out, prescaler_clr_out, discard_out};
         checked++;
         if (seen !== note_q[0]) begin
            fail_count++;
            $display("unexpected outputs exp %h got %h", note_q[0], seen);
         end
         void'(note_q.pop_front());
      end
   end

   initial begin
      void'($urandom(77));
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      note_q.push_back(29'h0);
      repeat (400) step();
      @(negedge clk_in);
      final_report();
   end

   // 400 slots take about 2 us
   initial begin
      #10000;
      fail_count++;
      final_report();
   end
endmodule
